// file: verilog/rspe_pkg.sv
package rspe_pkg;
	localparam int RSPE_CLK_MHZ     = 25;
	localparam int RSPE_PERIOD_US   = 256;
	localparam int RSPE_PERIOD_CYC  = RSPE_PERIOD_US * RSPE_CLK_MHZ;
	localparam int RSPE_TMR_W       = 16;
	localparam int RSPE_SLOTS       = 100;
	localparam int RSPE_MEM_DEPTH   = RSPE_SLOTS - 1;
	localparam int RSPE_POS_W       = 7;
	localparam logic [RSPE_POS_W-1:0] RSPE_FIRST_SLOT = 7'h00;
	localparam logic [RSPE_POS_W-1:0] RSPE_LAST_SLOT  = 7'h63;
	localparam logic [RSPE_POS_W-1:0] RSPE_POS_ONE    = 7'h01;
	localparam logic [3:0]  RSPE_BURST_LAST  = 4'hf;
	localparam logic [7:0]  RSPE_NUL         = 8'h00;
	localparam logic [7:0]  RSPE_DELETE_CHAR = 8'h7f;
	localparam logic [15:0] RSPE_ENTRY_GUARD = 16'h0020;
	localparam logic [1:0]  RSPE_PAUSE_EXECS = 2'h2;
	// register byte offsets
	localparam logic [4:0] RSPE_REG_CTRL   = 5'h00;
	localparam logic [4:0] RSPE_REG_STATUS = 5'h04;
	localparam logic [4:0] RSPE_REG_POS    = 5'h08;
	localparam logic [4:0] RSPE_REG_CURSOR = 5'h0c;
	localparam logic [4:0] RSPE_REG_DATA   = 5'h10;
	// control bits
	localparam int RSPE_CTRL_RUN  = 0;
	localparam int RSPE_CTRL_EXIT = 1;
	localparam logic RSPE_RUN_RESET = 1'b1;
	// status bits
	localparam int RSPE_ST_COMPOSE = 0;
	localparam int RSPE_ST_REFRESH = 1;
	localparam int RSPE_ST_EDIT    = 2;
	localparam int RSPE_ST_INSERT  = 3;
	localparam int RSPE_ST_BYPASS  = 4;
	localparam int RSPE_ST_PAUSE   = 5;
	localparam int RSPE_ST_RESTORE = 6;
	localparam int RSPE_ST_MATCH   = 7;
	localparam int RSPE_ST_GLYPH   = 8;
	localparam int RSPE_ST_PEND    = 9;
	// cursor and data register fields
	localparam int RSPE_SAVED_LSB  = 8;
	localparam int RSPE_LATCH_LSB  = 8;

	typedef enum logic [2:0] {
		RSPE_SEQ_IDLE   = 3'b000,
		RSPE_SEQ_SHIFT  = 3'b001,
		RSPE_SEQ_SLOT   = 3'b010,
		RSPE_SEQ_STROBE = 3'b011,
		RSPE_SEQ_CHAR_EXECUTE   = 3'b100,
		RSPE_SEQ_SPACE  = 3'b101
	} rspe_seq_t;

	typedef enum logic [2:0] {
		RSPE_ENT_IDLE  = 3'b000,
		RSPE_ENT_LOAD  = 3'b001,
		RSPE_ENT_INPUT = 3'b010,
		RSPE_ENT_ARM   = 3'b011,
		RSPE_ENT_CLEAR = 3'b100,
		RSPE_ENT_SET   = 3'b101
	} rspe_ent_t;

	typedef struct packed {
		logic       strobe;
		logic [7:0] data;
		logic       edit;
		logic       insert;
		logic       pad_select_switch;
	} rspe_key_t;

	typedef struct packed {
		logic [7:0] display_data_bit;
		logic       memory_shift_clock;
		logic       cursor_match;
		logic       glyph_start;
		logic       view_timer_reset;
	} rspe_disp_t;

	typedef struct packed {
		logic [RSPE_POS_W-1:0] x_pos;
		logic                  x_advance_pulse;
		logic                  x_home_request;
		logic                  space_complete;
		logic                  function_complete;
	} rspe_beam_t;

	typedef struct packed {
		logic slot_execute;
		logic pad_strobe;
		logic char_execute;
		logic data_load_strobe;
		logic input_strobe;
		logic clear_set_arm;
		logic cursor_increment;
		logic cursor_decrement;
		logic saved_cursor_decrement;
		logic restore_cursor;
		logic loop_restore;
	} rspe_seq_out_t;
endpackage

// file: verilog/rspe_editor.sv
`timescale 1ns/1ns
module rspe_editor
	import rspe_pkg::*;
#(
	parameter int unsigned PERIOD_CYC = RSPE_PERIOD_CYC
) (
	input  wire logic                   sys_clk_i,
	input  wire logic                   rst_i,
	input  wire rspe_pkg::rspe_key_t    key_i,
	input  wire logic                   glyph_in_progress_i,
	input  wire logic [4:0]             avs_address_i,
	input  wire logic                   avs_read_i,
	input  wire logic                   avs_write_i,
	input  wire logic [31:0]            avs_writedata_i,
	input  wire logic [3:0]             avs_byteenable_i,
	output logic [31:0]                 avs_readdata_o,
	output logic                        avs_waitrequest_o,
	output logic                        compose_o,
	output logic                        compose_n_o,
	output logic                        refresh_flag_o,
	output logic                        receive_ready_o,
	output logic                        local_echo_enable_o,
	output logic                        pad_area_hold_o,
	output logic                        key_entry_enable_o,
	output logic                        edit_mode_flag_o,
	output logic                        edit_lamp_o,
	output logic                        insert_active_flag_o,
	output logic [7:0]                  latched_data_bit_o,
	output logic [7:0]                  send_data_bit_o,
	output rspe_pkg::rspe_disp_t        disp_o,
	output rspe_pkg::rspe_beam_t        beam_o,
	output rspe_pkg::rspe_seq_out_t     seq_o
);
	import rspe_pkg::*;

	localparam logic [RSPE_TMR_W-1:0] TMR_RELOAD = RSPE_TMR_W'(PERIOD_CYC - 1);

	typedef logic [RSPE_POS_W-1:0] rspe_pos_t;

	function automatic rspe_pos_t rspe_inc(input rspe_pos_t v);
		rspe_inc = (v == RSPE_LAST_SLOT) ? RSPE_FIRST_SLOT : v + RSPE_POS_ONE;
	endfunction

	function automatic rspe_pos_t rspe_dec(input rspe_pos_t v);
		rspe_dec = (v == RSPE_FIRST_SLOT) ? RSPE_LAST_SLOT : v - RSPE_POS_ONE;
	endfunction

	// core state
	rspe_seq_t             st_q, st_d;
	rspe_ent_t             ent_q, ent_d;
	logic [RSPE_TMR_W-1:0] tmr_q, tmr_d;
	logic [3:0]            bit_q, bit_d;
	logic [7:0]            mem_q [RSPE_MEM_DEPTH];
	logic [7:0]            mem_d [RSPE_MEM_DEPTH];
	rspe_pos_t             ptr_q, ptr_d;
	logic [7:0]            win_q, win_d;
	logic [7:0]            ins_q, ins_d;
	logic [7:0]            lat_q, lat_d;
	logic [7:0]            pend_data_q, pend_data_d;
	logic                  pend_q, pend_d;
	rspe_pos_t             pos_q, pos_d;
	rspe_pos_t             cur_q, cur_d;
	rspe_pos_t             saved_q, saved_d;
	logic                  compose_q, compose_d;
	logic                  edit_q, edit_d;
	logic                  edit_arm_q, edit_arm_d;
	logic                  ek_q, ek_d;
	logic                  insert_q, insert_d;
	logic                  bypass_q, bypass_d;
	logic                  del_q, del_d;
	logic                  inc_pend_q, inc_pend_d;
	logic [1:0]            pause_q, pause_d;
	logic                  run_q, run_d;
	logic                  exit_req;
	rspe_disp_t            disp_q, disp_d;
	rspe_beam_t            beam_q, beam_d;
	rspe_seq_out_t         seq_q, seq_d;

	always_comb begin
		st_d        = st_q;
		ent_d       = ent_q;
		bit_d       = bit_q;
		mem_d       = mem_q;
		ptr_d       = ptr_q;
		win_d       = win_q;
		ins_d       = ins_q;
		lat_d       = lat_q;
		pend_d      = pend_q;
		pend_data_d = pend_data_q;
		pos_d       = pos_q;
		cur_d       = cur_q;
		saved_d     = saved_q;
		compose_d   = compose_q;
		edit_d      = edit_q;
		edit_arm_d  = edit_arm_q;
		ek_d        = key_i.edit;
		insert_d    = insert_q;
		bypass_d    = bypass_q;
		del_d       = del_q;
		inc_pend_d  = inc_pend_q;
		pause_d     = pause_q;
		seq_d       = '0;
		seq_d.loop_restore = seq_q.loop_restore;
		beam_d      = beam_q;
		beam_d.x_advance_pulse   = 1'b0;
		beam_d.x_home_request    = 1'b0;
		beam_d.space_complete    = 1'b0;
		beam_d.function_complete = 1'b0;
		disp_d      = disp_q;
		disp_d.memory_shift_clock = 1'b0;
		disp_d.glyph_start        = 1'b0;
		disp_d.view_timer_reset   = 1'b0;
		tmr_d = (tmr_q == '0) ? TMR_RELOAD : tmr_q - 1'b1;

		// compose entry; strobes in compose queue a character instead
		if (key_i.strobe && !compose_q && key_i.pad_select_switch) begin
			compose_d = 1'b1;
		end else if (key_i.strobe && compose_q && !pend_q) begin
			pend_d      = 1'b1;
			pend_data_d = key_i.data;
		end

		// edit key: press saves or restores, release toggles the flag
		if (key_i.edit && !ek_q && compose_q) begin
			edit_arm_d = 1'b1;
			if (!edit_q) begin
				saved_d = cur_q;
			end else begin
				cur_d = saved_q;
				seq_d.restore_cursor = 1'b1;
			end
		end
		if (!key_i.edit && ek_q && edit_arm_q) begin
			edit_arm_d = 1'b0;
			edit_d     = !edit_q;
		end

		unique case (st_q)
			RSPE_SEQ_IDLE: begin
				if (tmr_q == '0 && compose_q && run_q) begin
					st_d  = RSPE_SEQ_SHIFT;
					bit_d = '0;
				end
			end
			RSPE_SEQ_SHIFT: begin
				bit_d = bit_q + 1'b1;
				disp_d.memory_shift_clock = !bit_q[0];
				if (bit_q == RSPE_BURST_LAST) begin
					// empty slots are plain nulls and move like any character
					win_d = mem_q[ptr_q];
					if (insert_q) begin
						mem_d[ptr_q] = ins_q;
						ins_d        = win_q;
					end else begin
						mem_d[ptr_q] = win_q;
					end
					ptr_d = (ptr_q == RSPE_POS_W'(RSPE_MEM_DEPTH - 1)) ? '0 : ptr_q + 1'b1;
					st_d  = RSPE_SEQ_SLOT;
					seq_d.slot_execute = 1'b1;
					pos_d = rspe_inc(pos_q);
					if (inc_pend_q) begin
						cur_d      = rspe_inc(cur_q);
						inc_pend_d = 1'b0;
						seq_d.cursor_increment = 1'b1;
					end
					if (edit_q && key_i.insert && !insert_q && disp_q.cursor_match) begin
						insert_d = 1'b1;
						ins_d    = RSPE_NUL;
					end
					if (pos_q == RSPE_LAST_SLOT) begin
						// first slot has entered: end loop restore and home the beam
						seq_d.loop_restore    = 1'b0;
						beam_d.x_home_request = 1'b1;
						beam_d.x_pos          = '0;
						pause_d               = RSPE_PAUSE_EXECS;
						bypass_d              = 1'b0;
						// the insert stage is dropped; its slot is assumed empty
						insert_d              = 1'b0;
					end else if (pos_d == RSPE_LAST_SLOT) begin
						seq_d.loop_restore = 1'b1;
					end
				end
			end
			RSPE_SEQ_SLOT: begin
				st_d = RSPE_SEQ_STROBE;
				seq_d.pad_strobe = 1'b1;
			end
			RSPE_SEQ_STROBE: begin
				st_d = RSPE_SEQ_CHAR_EXECUTE;
				if (pause_q == '0) begin
					seq_d.char_execute      = 1'b1;
					beam_d.x_advance_pulse  = 1'b1;
					disp_d.glyph_start      = 1'b1;
					disp_d.view_timer_reset = 1'b1;
					beam_d.x_pos = (beam_q.x_pos == RSPE_LAST_SLOT) ? '0 : beam_q.x_pos + 1'b1;
				end else begin
					pause_d = pause_q - 1'b1;
				end
			end
			RSPE_SEQ_CHAR_EXECUTE: begin
				st_d = RSPE_SEQ_SPACE;
				beam_d.space_complete = seq_q.char_execute;
			end
			RSPE_SEQ_SPACE: begin
				st_d = RSPE_SEQ_IDLE;
				// function complete carries no action while composing
				beam_d.function_complete = beam_q.space_complete;
			end
			default: st_d = RSPE_SEQ_IDLE;
		endcase

		// character entry runs only between bursts, never across one
		unique case (ent_q)
			RSPE_ENT_IDLE: begin
				if (pend_q && disp_q.cursor_match && st_q == RSPE_SEQ_IDLE
					&& tmr_q > RSPE_ENTRY_GUARD) begin
					ent_d  = RSPE_ENT_LOAD;
					pend_d = 1'b0;
					lat_d  = pend_data_q;
					seq_d.data_load_strobe = 1'b1;
					inc_pend_d = 1'b1;
					del_d = edit_q && !insert_q && pend_data_q == RSPE_DELETE_CHAR;
					if (edit_q && !insert_q && pend_data_q == RSPE_DELETE_CHAR) begin
						cur_d    = rspe_dec(cur_q);
						saved_d  = rspe_dec(saved_q);
						bypass_d = 1'b1;
						seq_d.cursor_decrement       = 1'b1;
						seq_d.saved_cursor_decrement = 1'b1;
					end else if (insert_q) begin
						saved_d = rspe_inc(saved_q);
					end
				end
			end
			RSPE_ENT_LOAD: begin
				ent_d = RSPE_ENT_INPUT;
				seq_d.input_strobe = 1'b1;
			end
			RSPE_ENT_INPUT: begin
				ent_d = RSPE_ENT_ARM;
				seq_d.clear_set_arm = 1'b1;
			end
			RSPE_ENT_ARM: begin
				ent_d = RSPE_ENT_CLEAR;
				if (insert_q) begin
					ins_d = RSPE_NUL;
				end else begin
					win_d = RSPE_NUL;
				end
			end
			RSPE_ENT_CLEAR: begin
				ent_d = RSPE_ENT_SET;
				if (del_q) begin
					lat_d = RSPE_NUL;
					beam_d.function_complete = 1'b1;
				end else if (insert_q) begin
					ins_d = lat_q;
				end else begin
					win_d = lat_q;
				end
			end
			RSPE_ENT_SET: begin
				ent_d = RSPE_ENT_IDLE;
				del_d = 1'b0;
			end
			default: ent_d = RSPE_ENT_IDLE;
		endcase

		// exit must win before match is formed, or entry enable outlives compose
		if (exit_req) begin
			compose_d = 1'b0;
			edit_d    = 1'b0;
			insert_d  = 1'b0;
			pend_d    = 1'b0;
		end

		disp_d.display_data_bit = win_d;
		disp_d.cursor_match     = compose_d && (cur_d == pos_d);
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			st_q        <= RSPE_SEQ_IDLE;
			ent_q       <= RSPE_ENT_IDLE;
			tmr_q       <= '0;
			bit_q       <= '0;
			ptr_q       <= '0;
			win_q       <= RSPE_NUL;
			ins_q       <= RSPE_NUL;
			lat_q       <= RSPE_NUL;
			pend_q      <= 1'b0;
			pend_data_q <= RSPE_NUL;
			pos_q       <= RSPE_FIRST_SLOT;
			cur_q       <= RSPE_FIRST_SLOT;
			saved_q     <= RSPE_FIRST_SLOT;
			compose_q   <= 1'b0;
			edit_q      <= 1'b0;
			edit_arm_q  <= 1'b0;
			ek_q        <= 1'b0;
			insert_q    <= 1'b0;
			bypass_q    <= 1'b0;
			del_q       <= 1'b0;
			inc_pend_q  <= 1'b0;
			pause_q     <= '0;
			disp_q      <= '0;
			beam_q      <= '0;
			seq_q       <= '0;
			for (int i = 0; i < RSPE_MEM_DEPTH; i++) begin
				mem_q[i] <= RSPE_NUL;
			end
		end else begin
			st_q        <= st_d;
			ent_q       <= ent_d;
			tmr_q       <= tmr_d;
			bit_q       <= bit_d;
			mem_q       <= mem_d;
			ptr_q       <= ptr_d;
			win_q       <= win_d;
			ins_q       <= ins_d;
			lat_q       <= lat_d;
			pend_q      <= pend_d;
			pend_data_q <= pend_data_d;
			pos_q       <= pos_d;
			cur_q       <= cur_d;
			saved_q     <= saved_d;
			compose_q   <= compose_d;
			edit_q      <= edit_d;
			edit_arm_q  <= edit_arm_d;
			ek_q        <= ek_d;
			insert_q    <= insert_d;
			bypass_q    <= bypass_d;
			del_q       <= del_d;
			inc_pend_q  <= inc_pend_d;
			pause_q     <= pause_d;
			disp_q      <= disp_d;
			beam_q      <= beam_d;
			seq_q       <= seq_d;
		end
	end

	// avalon slave: one wait cycle, then a single answer cycle
	logic        ack_q, ack_d;
	logic [31:0] rdata_q, rdata_d;
	logic        wr_ok;

	always_comb begin
		ack_d    = (avs_read_i || avs_write_i) && !ack_q;
		rdata_d  = rdata_q;
		run_d    = run_q;
		wr_ok    = ack_d && avs_write_i && avs_address_i == RSPE_REG_CTRL && avs_byteenable_i[0];
		exit_req = wr_ok && avs_writedata_i[RSPE_CTRL_EXIT];
		if (wr_ok) begin
			run_d = avs_writedata_i[RSPE_CTRL_RUN];
		end
		if (ack_d && avs_read_i) begin
			rdata_d = '0;
			unique case (avs_address_i)
				RSPE_REG_CTRL:   rdata_d[RSPE_CTRL_RUN] = run_q;
				RSPE_REG_STATUS: begin
					rdata_d[RSPE_ST_COMPOSE] = compose_q;
					rdata_d[RSPE_ST_REFRESH] = compose_q;
					rdata_d[RSPE_ST_EDIT]    = edit_q;
					rdata_d[RSPE_ST_INSERT]  = insert_q;
					rdata_d[RSPE_ST_BYPASS]  = bypass_q;
					rdata_d[RSPE_ST_PAUSE]   = pause_q != '0;
					rdata_d[RSPE_ST_RESTORE] = seq_q.loop_restore;
					rdata_d[RSPE_ST_MATCH]   = disp_q.cursor_match;
					rdata_d[RSPE_ST_GLYPH]   = glyph_in_progress_i;
					rdata_d[RSPE_ST_PEND]    = pend_q;
				end
				RSPE_REG_POS:    rdata_d[RSPE_POS_W-1:0] = pos_q;
				RSPE_REG_CURSOR: begin
					rdata_d[RSPE_POS_W-1:0] = cur_q;
					rdata_d[RSPE_SAVED_LSB +: RSPE_POS_W] = saved_q;
				end
				RSPE_REG_DATA: begin
					rdata_d[7:0] = win_q;
					rdata_d[RSPE_LATCH_LSB +: 8] = lat_q;
				end
				default: rdata_d = '0;
			endcase
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			ack_q   <= 1'b0;
			rdata_q <= '0;
			run_q   <= RSPE_RUN_RESET;
		end else begin
			ack_q   <= ack_d;
			rdata_q <= rdata_d;
			run_q   <= run_d;
		end
	end

	// compose, refresh and echo share one flag in refreshed operation
	logic comp_n_q;
	logic rdy_q;
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			comp_n_q <= 1'b1;
			rdy_q    <= 1'b1;
		end else begin
			comp_n_q <= !compose_d;
			rdy_q    <= !compose_d;
		end
	end

	assign avs_waitrequest_o    = !ack_q;
	assign avs_readdata_o       = rdata_q;
	assign compose_o            = compose_q;
	assign compose_n_o          = comp_n_q;
	assign refresh_flag_o       = compose_q;
	assign receive_ready_o      = rdy_q;
	assign local_echo_enable_o  = !rdy_q;
	assign pad_area_hold_o      = compose_q;
	assign key_entry_enable_o   = disp_q.cursor_match;
	assign edit_mode_flag_o     = edit_q;
	assign edit_lamp_o          = edit_q;
	assign insert_active_flag_o = insert_q;
	assign latched_data_bit_o   = lat_q;
	assign send_data_bit_o      = win_q;
	assign disp_o               = disp_q;
	assign beam_o               = beam_q;
	assign seq_o                = seq_q;

	chk_compose_entry: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		key_i.strobe && key_i.pad_select_switch && !compose_q && !exit_req
		|=> compose_o && !compose_n_o && refresh_flag_o)
		else $error("compose not entered on strobe");
	chk_echo_refresh: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		refresh_flag_o |-> !receive_ready_o && local_echo_enable_o)
		else $error("ready or echo wrong during refresh");
	chk_burst_slot: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		st_q == RSPE_SEQ_IDLE ##1 st_q == RSPE_SEQ_SHIFT |-> ##16 seq_o.slot_execute)
		else $error("slot execute not after sixteen shift cycles");
	chk_char_execute_order: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		seq_o.slot_execute |=> seq_o.pad_strobe ##1 (seq_o.char_execute == (pause_q == '0)
		|| seq_o.char_execute == ($past(pause_q) == '0)))
		else $error("strobe or execute out of order");
	chk_pos_step: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		seq_o.slot_execute |-> pos_q == rspe_inc($past(pos_q)))
		else $error("position counter did not step");
	chk_x_step: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		beam_o.x_advance_pulse |=> beam_o.space_complete ##1 beam_o.function_complete)
		else $error("space or function complete missing");
	chk_restore_last: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		seq_o.slot_execute && pos_q == RSPE_LAST_SLOT |-> seq_o.loop_restore)
		else $error("loop restore not raised at last slot");
	chk_pause_home: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		beam_o.x_home_request |-> beam_o.x_pos == '0 && !seq_o.loop_restore
		##2 !seq_o.char_execute && !beam_o.x_advance_pulse)
		else $error("execute not held off during pause");
	chk_match_enable: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		key_entry_enable_o == (compose_o && cur_q == pos_q))
		else $error("entry enable disagrees with cursor match");
	chk_clear_set: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		seq_o.data_load_strobe |=> seq_o.input_strobe ##1 seq_o.clear_set_arm)
		else $error("clear and set sequence broken");
	chk_edit_save: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		key_i.edit && !ek_q && compose_q && !edit_q && !exit_req |=> saved_q == $past(cur_q))
		else $error("cursor not saved on edit");
endmodule

// file: bench/rspe_glyph_model.sv
`timescale 1ns/1ns
module rspe_glyph_model #(
	parameter int unsigned GLYPH_CYC = 12
) (
	input  wire logic sys_clk_i,
	input  wire logic rst_i,
	input  wire logic glyph_start_i,
	output logic      glyph_in_progress_o
);
	// scan length is a parameter so the generator can answer fast or slow
	int unsigned left_q;
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			left_q <= 0;
		end else if (glyph_start_i) begin
			left_q <= GLYPH_CYC;
		end else if (left_q != 0) begin
			left_q <= left_q - 1;
		end
	end
	// busy while scanning, drops at scan end
	assign glyph_in_progress_o = (left_q != 0);
endmodule

// file: bench/test_rspe_editor.sv
`timescale 1ns/1ns
module test_rspe_editor;
	import rspe_pkg::*;
	localparam int unsigned PCYC = 64;
	logic sys_clk_i, rst_i, avs_read_i, avs_write_i, gip;
	logic [4:0]  avs_address_i;
	logic [31:0] avs_writedata_i, avs_readdata_o, rd;
	logic [3:0]  avs_byteenable_i;
	logic avs_waitrequest_o, compose_o, compose_n_o, refresh_flag_o, receive_ready_o;
	logic local_echo_enable_o, pad_area_hold_o, key_entry_enable_o, edit_mode_flag_o;
	logic edit_lamp_o, insert_active_flag_o, seen;
	logic [7:0] latched_data_bit_o, send_data_bit_o;
	rspe_key_t key_i;
	rspe_disp_t disp_o;
	rspe_beam_t beam_o;
	rspe_seq_out_t seq_o;
	int failures, compares, cycles, n, clk_n;
	// register reads after reset, the last at unmapped address 5'h14: address, mask, expected value
	logic [4:0]  r_adr [5] = '{RSPE_REG_CTRL, RSPE_REG_STATUS, RSPE_REG_POS, RSPE_REG_CURSOR, 5'h14};
	logic [31:0] r_msk [5] = '{32'h1, 32'h3ff, 32'h7f, 32'h7f7f, 32'hffffffff};
	logic [31:0] r_exp [5] = '{32'h1, 32'h0, 32'h0, 32'h0, 32'h0};
	rspe_editor #(.PERIOD_CYC(PCYC)) rspe_editor_inst (.*, .glyph_in_progress_i(gip));
	rspe_glyph_model rspe_glyph_model_inst (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
		.glyph_start_i(disp_o.glyph_start), .glyph_in_progress_o(gip));
	initial begin
		sys_clk_i = 0;
		forever #20 sys_clk_i = ~sys_clk_i;
	end
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	task bus_rd(input logic [4:0] a, output logic [31:0] d);
		avs_address_i <= a;
		avs_read_i <= 1'b1;
		do @(posedge sys_clk_i); while (avs_waitrequest_o !== 1'b0);
		d = avs_readdata_o;
		avs_read_i <= 1'b0;
		@(posedge sys_clk_i);
	endtask
	task tick(input int k);
		repeat (k) @(posedge sys_clk_i);
	endtask
	task final_report;
		$display("compares=%0d failures=%0d", compares, failures);
		if (failures == 0 && compares > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	always @(posedge sys_clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			failures++;
			final_report;
		end
	end
	initial begin
		{avs_read_i, avs_write_i, avs_address_i, avs_writedata_i} = '0;
		avs_byteenable_i = 4'hf;
		key_i = '0;
		rst_i = 1'b1;
		tick(8);
		rst_i <= 1'b0;
		@(posedge sys_clk_i);
		chk("compose_n", 1, compose_n_o);
		chk("rcv_ready", 2'b10, {receive_ready_o, compose_o});
		for (int i = 0; i < 5; i++) begin
			bus_rd(r_adr[i], rd);
			chk("reg", r_exp[i], rd & r_msk[i]);
		end
		// compose entry from a key strobe with the pad switch on
		key_i.pad_select_switch <= 1'b1;
		key_i.strobe <= 1'b1;
		tick(1);
		key_i.strobe <= 1'b0;
		tick(2);
		chk("mode", 5'b10101, {compose_o, compose_n_o, refresh_flag_o, receive_ready_o,
			local_echo_enable_o});
		// one burst: eight shift clocks, one period, position steps
		do @(posedge sys_clk_i); while (seq_o.slot_execute !== 1'b1);
		n = 0;
		clk_n = 0;
		do begin
			@(posedge sys_clk_i);
			n++;
			if (disp_o.memory_shift_clock === 1'b1) clk_n++;
		end while (seq_o.slot_execute !== 1'b1);
		chk("shift_clks", 8, clk_n);
		chk("period", PCYC, n);
		bus_rd(RSPE_REG_POS, rd);
		n = rd[6:0];
		do @(posedge sys_clk_i); while (seq_o.slot_execute !== 1'b1);
		bus_rd(RSPE_REG_POS, rd);
		chk("pos_step", (n + 1) % RSPE_SLOTS, rd & 32'h7f);
		// character entry waits for the cursor slot
		key_i.data <= 8'h41;
		key_i.strobe <= 1'b1;
		tick(1);
		key_i.strobe <= 1'b0;
		do @(posedge sys_clk_i); while (seq_o.data_load_strobe !== 1'b1);
		chk("entry_en", 1, key_entry_enable_o);
		tick(1);
		chk("latch", 8'h41, latched_data_bit_o);
		tick(3);
		chk("window", 8'h41, send_data_bit_o);
		do @(posedge sys_clk_i); while (seq_o.cursor_increment !== 1'b1);
		tick(1);
		bus_rd(RSPE_REG_CURSOR, rd);
		chk("cursor", 1, rd & 32'h7f);
		// edit press saves the cursor, release lights the lamp
		key_i.edit <= 1'b1;
		tick(3);
		key_i.edit <= 1'b0;
		tick(3);
		chk("edit_on", 2'b11, {edit_mode_flag_o, edit_lamp_o});
		bus_rd(RSPE_REG_CURSOR, rd);
		chk("saved", 32'h0101, rd & 32'h7f7f);
		key_i.edit <= 1'b1;
		seen = 1'b0;
		repeat (3) begin
			@(posedge sys_clk_i);
			if (seq_o.restore_cursor === 1'b1) seen = 1'b1;
		end
		key_i.edit <= 1'b0;
		tick(3);
		chk("restore", 1, seen);
		chk("edit_off", 2'b00, {edit_mode_flag_o, edit_lamp_o});
		// wrap to the first slot homes the beam
		do @(posedge sys_clk_i); while (beam_o.x_home_request !== 1'b1);
		tick(2);
		chk("x_home", 0, beam_o.x_pos);
		final_report;
	end
endmodule
